//--- design/pio_port.v
// parallel io port with edge capture and maskable interrupt output
// assumes one clock domain for the slave port; port inputs may be asynchronous
`timescale 1ns/10ps
`include "pio_consts.vh"

// Functional notes
// - port width parameter from 1 to 32
// - data read returns inputs, not written value
// - data write updates output drive register
// - exactly one direction mode per build
// - bidirectional: per-bit direction, input means undriven
// - separate mode: two independent full-width buses
// - output register loads configurable reset value
// - edge kind fixed at build time
// - configured edge sets matching edge flag
// - edge flags exist only with synchronous capture
// - bit-clear option: writing one clears that flag
// - level interrupt: high input and enable set
// - edge interrupt: flag set and enable set
// - interrupt maskable per input port
// - set/clear option adds two output write registers
// - output-only mode omits all input features
// - single slave port with plain read/write
// - no bit-clear: any edge write clears all
// - direction resets to zero, pins undriven
// - interrupt enables reset to zero
// - edge interrupt holds until mask cleared or flags written
module pio_port #(
  parameter       WIDTH      = 32,
  parameter [1:0] DIR_MODE   = `PIO_MODE_INOUT,
  parameter       HAS_EDGE   = 1,
  parameter [1:0] EDGE_KIND  = `PIO_EDGE_RISE,
  parameter       BIT_CLEAR  = 1,
  parameter       HAS_IRQ    = 1,
  parameter       IRQ_EDGE   = 1,
  parameter       HAS_SETCLR = 1,
  parameter [31:0] OUT_RESET = `PIO_OUT_RST
) (
  input  wire                    clock,
  input  wire                    nrst,
  input  wire [`PIO_ADDR_W-1:0]  regAddr,
  input  wire                    regWrite,
  input  wire                    regRead,
  input  wire [`PIO_BUS_W-1:0]   regWdata,
  output reg  [`PIO_BUS_W-1:0]   regRdata,
  output reg                     regRvalid,
  output reg                     irq,
  input  wire [WIDTH-1:0]        portIn,
  output reg  [WIDTH-1:0]        portOut,
  output reg  [WIDTH-1:0]        portOe
);

  // build-time feature selection
  localparam HAS_IN   = (DIR_MODE != `PIO_MODE_OUT) ? 1 : 0;
  localparam HAS_OUT  = (DIR_MODE != `PIO_MODE_IN) ? 1 : 0;
  localparam HAS_DIR  = (DIR_MODE == `PIO_MODE_BIDIR) ? 1 : 0;
  localparam EDGE_ON  = (HAS_IN == 1 && HAS_EDGE != 0) ? 1 : 0;
  localparam IRQ_ON   = (HAS_IN == 1 && HAS_IRQ != 0) ? 1 : 0;
  localparam IRQ_EDGE_ON = (IRQ_ON == 1 && IRQ_EDGE != 0 && EDGE_ON == 1) ? 1 : 0;
  localparam SC_ON    = (HAS_OUT == 1 && HAS_SETCLR != 0) ? 1 : 0;

  localparam [WIDTH-1:0] OUT_RST_W  = OUT_RESET[WIDTH-1:0];
  localparam [31:0]      DIR_RST_32  = `PIO_DIR_RST;
  localparam [31:0]      MASK_RST_32 = `PIO_MASK_RST;
  localparam [31:0]      EDGE_RST_32 = `PIO_EDGE_RST;
  localparam [WIDTH-1:0] DIR_RST_W  = DIR_RST_32[WIDTH-1:0];
  localparam [WIDTH-1:0] MASK_RST_W = MASK_RST_32[WIDTH-1:0];
  localparam [WIDTH-1:0] EDGE_RST_W = EDGE_RST_32[WIDTH-1:0];
  localparam [WIDTH-1:0] ALL_ONES   = {WIDTH{1'b1}};
  localparam [WIDTH-1:0] ALL_ZEROS  = {WIDTH{1'b0}};

  // register decode strobes
  wire wrData   = regWrite && (regAddr == `PIO_REG_DATA);
  wire wrDir    = regWrite && (regAddr == `PIO_REG_DIR);
  wire wrMask   = regWrite && (regAddr == `PIO_REG_IRQMASK);
  wire wrEdge   = regWrite && (regAddr == `PIO_REG_EDGE);
  wire wrOutSet = regWrite && (regAddr == `PIO_REG_OUTSET);
  wire wrOutClr = regWrite && (regAddr == `PIO_REG_OUTCLR);
  wire [WIDTH-1:0] wdataW = regWdata[WIDTH-1:0];

  reg  [WIDTH-1:0] outData_q;
  reg  [WIDTH-1:0] outData_d;
  reg  [WIDTH-1:0] dir_q;
  reg  [WIDTH-1:0] mask_q;
  reg  [WIDTH-1:0] edgeFlag_q;
  wire [WIDTH-1:0] edgeFlag_d;
  reg  [WIDTH-1:0] inPrev_q;
  wire [WIDTH-1:0] inSync;
  wire [WIDTH-1:0] edgeEvent;
  wire [WIDTH-1:0] edgeClr;
  reg  [`PIO_BUS_W-1:0] rdMux;
  reg              irq_d;

  // input path; in bidirectional mode this samples the pin, driven or not
  generate
    if (HAS_IN == 1) begin : g_in
      pio_in_sync #(
        .WIDTH (WIDTH)
      ) u_sync (
        .clock   (clock),
        .nrst    (nrst),
        .asyncIn (portIn),
        .syncOut (inSync)
      );
    end else begin : g_no_in
      assign inSync = ALL_ZEROS;
    end
  endgenerate

  // output drive register
  always @* begin
    outData_d = outData_q;
    if (HAS_OUT == 1) begin
      if (wrData) begin
        outData_d = wdataW;
      end else if (SC_ON == 1 && wrOutSet) begin
        outData_d = outData_q | wdataW;
      end else if (SC_ON == 1 && wrOutClr) begin
        outData_d = outData_q & ~wdataW;
      end
    end
  end

  always @(posedge clock) begin
    if (!nrst) begin
      outData_q <= OUT_RST_W;
    end else begin
      outData_q <= outData_d;
    end
  end

  // direction and interrupt enable registers
  always @(posedge clock) begin
    if (!nrst) begin
      dir_q  <= DIR_RST_W;
      mask_q <= MASK_RST_W;
    end else begin
      if (HAS_DIR == 1 && wrDir) begin
        dir_q <= wdataW;
      end
      if (IRQ_ON == 1 && wrMask) begin
        mask_q <= wdataW;
      end
    end
  end

  // per-bit edge detection and sticky flags
  assign edgeClr = !wrEdge ? ALL_ZEROS :
                   (BIT_CLEAR != 0) ? wdataW :
                   ALL_ONES;

  genvar gb;
  generate
    for (gb = 0; gb < WIDTH; gb = gb + 1) begin : g_edge
      if (EDGE_ON == 1) begin : g_on
        // kind is a parameter only, so software cannot retarget it
        if (EDGE_KIND == `PIO_EDGE_RISE) begin : g_rise
          assign edgeEvent[gb] = inSync[gb] & ~inPrev_q[gb];
        end else if (EDGE_KIND == `PIO_EDGE_FALL) begin : g_fall
          assign edgeEvent[gb] = ~inSync[gb] & inPrev_q[gb];
        end else begin : g_any
          assign edgeEvent[gb] = inSync[gb] ^ inPrev_q[gb];
        end
        // a new edge in the clearing cycle is kept: set beats clear
        assign edgeFlag_d[gb] = (edgeFlag_q[gb] & ~edgeClr[gb]) | edgeEvent[gb];
        always @(posedge clock) begin
          if (!nrst) begin
            inPrev_q[gb]   <= 1'b0;
            edgeFlag_q[gb] <= EDGE_RST_W[gb];
          end else begin
            inPrev_q[gb]   <= inSync[gb];
            edgeFlag_q[gb] <= edgeFlag_d[gb];
          end
        end
      end else begin : g_off
        assign edgeEvent[gb]  = 1'b0;
        assign edgeFlag_d[gb] = 1'b0;
        always @(posedge clock) begin
          inPrev_q[gb]   <= 1'b0;
          edgeFlag_q[gb] <= 1'b0;
        end
      end
    end
  endgenerate

  // interrupt source: levels or sticky flags, gated per port
  always @* begin
    irq_d = 1'b0;
    if (IRQ_ON == 1) begin
      if (IRQ_EDGE_ON == 1) begin
        irq_d = |(edgeFlag_q & mask_q);
      end else begin
        irq_d = |(inSync & mask_q);
      end
    end
  end

  // read mux; absent registers read as zero
  always @* begin
    rdMux = {`PIO_BUS_W{1'b0}};
    if (regAddr == `PIO_REG_DATA) begin
      if (HAS_IN == 1) begin
        rdMux[WIDTH-1:0] = inSync;
      end
    end else if (regAddr == `PIO_REG_DIR) begin
      if (HAS_DIR == 1) begin
        rdMux[WIDTH-1:0] = dir_q;
      end
    end else if (regAddr == `PIO_REG_IRQMASK) begin
      if (IRQ_ON == 1) begin
        rdMux[WIDTH-1:0] = mask_q;
      end
    end else if (regAddr == `PIO_REG_EDGE) begin
      if (EDGE_ON == 1) begin
        rdMux[WIDTH-1:0] = edgeFlag_q;
      end
    end
  end

  // slave answers one cycle after the request
  always @(posedge clock) begin
    if (!nrst) begin
      regRdata  <= {`PIO_BUS_W{1'b0}};
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead) begin
        regRdata <= rdMux;
      end
    end
  end

  // pins and interrupt line come straight from flops
  always @(posedge clock) begin
    if (!nrst) begin
      irq     <= 1'b0;
      portOut <= ALL_ZEROS;
      portOe  <= ALL_ZEROS;
    end else begin
      irq <= irq_d;
      case (DIR_MODE)
        `PIO_MODE_BIDIR: begin
          portOut <= outData_d;
          portOe  <= (HAS_DIR == 1 && wrDir) ? wdataW : dir_q;
        end
        `PIO_MODE_IN: begin
          portOut <= ALL_ZEROS;
          portOe  <= ALL_ZEROS;
        end
        default: begin
          portOut <= outData_d;
          portOe  <= ALL_ONES;
        end
      endcase
    end
  end

  // width range guard is structural: slicing fails to elaborate outside 1..32
  localparam [0:0] WIDTH_OK = (WIDTH >= 1 && WIDTH <= `PIO_MAX_W) ? 1'b1 : 1'b0;
  wire [WIDTH_OK:WIDTH_OK] widthGuard = WIDTH_OK;

endmodule // pio_port

//--- design/pio_consts.vh
// constants for the parallel io port: register indices, generation-time
// mode encodings and reset values; assumes inclusion by the io port files
`ifndef PIO_CONSTS_VH
`define PIO_CONSTS_VH

// register indices on the slave port, one 32-bit word each
`define PIO_ADDR_W        3
`define PIO_REG_DATA      3'h0
`define PIO_REG_DIR       3'h1
`define PIO_REG_IRQMASK   3'h2
`define PIO_REG_EDGE      3'h3
`define PIO_REG_OUTSET    3'h4
`define PIO_REG_OUTCLR    3'h5

`define PIO_BUS_W         32
`define PIO_MAX_W         32

// direction modes
`define PIO_MODE_BIDIR    2'h0
`define PIO_MODE_IN       2'h1
`define PIO_MODE_OUT      2'h2
`define PIO_MODE_INOUT    2'h3

// edge kinds
`define PIO_EDGE_RISE     2'h0
`define PIO_EDGE_FALL     2'h1
`define PIO_EDGE_ANY      2'h2

// reset values
`define PIO_DIR_RST       32'h0000_0000
`define PIO_MASK_RST      32'h0000_0000
`define PIO_EDGE_RST      32'h0000_0000
`define PIO_OUT_RST       32'h0000_0000

`endif

//--- design/pio_in_sync.v
// three-stage input synchroniser with agreement filter for the io port
// assumes the inputs are asynchronous to clock; one instance per port
`timescale 1ns/10ps

module pio_in_sync #(
  parameter WIDTH = 32
) (
  input  wire             clock,
  input  wire             nrst,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;
  reg [WIDTH-1:0] stage3_q;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      // a change is only accepted once the second and third stages agree
      always @(posedge clock) begin
        if (!nrst) begin
          stage1_q[gi] <= 1'b0;
          stage2_q[gi] <= 1'b0;
          stage3_q[gi] <= 1'b0;
          syncOut[gi]  <= 1'b0;
        end else begin
          stage1_q[gi] <= asyncIn[gi];
          stage2_q[gi] <= stage1_q[gi];
          stage3_q[gi] <= stage2_q[gi];
          if (stage2_q[gi] == stage3_q[gi]) begin
            syncOut[gi] <= stage3_q[gi];
          end
        end
      end
    end
  endgenerate

endmodule // pio_in_sync

//--- test/pio_port_monitor.sv
// assertions on the io port register strobes, pins and interrupt
// assumes a bidir build bound to every pio_port instance
`timescale 1ns/10ps
`include "pio_consts.vh"
module pio_port_monitor #(
  parameter        WIDTH     = 32,
  parameter [31:0] OUT_RESET = 32'h0
) (
  input wire logic             clock,
  input wire logic             nrst,
  input wire logic [2:0]       regAddr,
  input wire logic             regWrite,
  input wire logic             regRead,
  input wire logic [31:0]      regWdata,
  input wire logic [31:0]      regRdata,
  input wire logic             regRvalid,
  input wire logic             irq,
  input wire logic [WIDTH-1:0] portIn,
  input wire logic [WIDTH-1:0] portOut,
  input wire logic [WIDTH-1:0] portOe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire [WIDTH-1:0] wd = regWdata[WIDTH-1:0];
  a_read_answer: assert property (regRead |=> regRvalid && (regRdata >> WIDTH) == 0)
    else $error("read not answered");
  a_valid_cause: assert property (regRvalid |-> $past(regRead))
    else $error("spurious read valid");
  a_data_drive: assert property (regWrite && regAddr == `PIO_REG_DATA |=> portOut == $past(wd))
    else $error("data write not driven");
  a_dir_drive: assert property (regWrite && regAddr == `PIO_REG_DIR |=> portOe == $past(wd))
    else $error("direction not applied");
  a_set_bits: assert property (regWrite && regAddr == `PIO_REG_OUTSET |=> portOut == ($past(portOut) | $past(wd)))
    else $error("set bits wrong");
  a_clr_bits: assert property (regWrite && regAddr == `PIO_REG_OUTCLR |=> portOut == ($past(portOut) & ~$past(wd)))
    else $error("clear bits wrong");
  a_reset_load: assert property ($rose(nrst) && !regWrite |=> portOut == OUT_RESET[WIDTH-1:0] && portOe == 0)
    else $error("reset value wrong");
  a_irq_quiet: assert property ($rose(nrst) |-> !irq ##1 !irq)
    else $error("irq after reset");
  // mask lands on the edge that samples the write, irq flop one edge later, sampled one edge after that, with one edge spare
  a_mask_ack: assert property (regWrite && regAddr == `PIO_REG_IRQMASK && wd == 0 |-> ##3 !irq)
    else $error("irq not acknowledged");
  a_unmapped_zero: assert property (regRead && regAddr > 3'h5 |=> regRdata == 0)
    else $error("unmapped read not zero");
  c_read: cover property (regRead ##1 regRvalid);
  c_irq: cover property ($rose(irq));
  c_clr: cover property (regWrite && regAddr == `PIO_REG_OUTCLR);
endmodule // pio_port_monitor
bind pio_port pio_port_monitor #(.WIDTH(WIDTH), .OUT_RESET(OUT_RESET)) i_mon (.clock(clock), .nrst(nrst),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
  .regRvalid(regRvalid), .irq(irq), .portIn(portIn), .portOut(portOut), .portOe(portOe));

//--- test/pio_pin_model.sv
// pin model for the bidir io port: resolves port drive against external logic
// assumes external logic drives every pin the port leaves undriven
`timescale 1ns/10ps
module pio_pin_model #(
  parameter WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] portOut,
  input  wire logic [WIDTH-1:0] portOe,
  input  wire logic [WIDTH-1:0] extDrive,
  output wire logic [WIDTH-1:0] pinLevel
);
  assign pinLevel = (portOut & portOe) | (extDrive & ~portOe);
endmodule // pio_pin_model

//--- test/tb_parallel_io_port_with_irq.sv
// self-checking bench for the io port in bidir mode with rising edge capture
// assumes the pin model closes the pins; expectations come from integer models
`timescale 1ns/10ps
`include "pio_consts.vh"
module tb_parallel_io_port_with_irq;
  localparam W = 8;
  localparam [31:0] RST_OUT = 32'h0000_00A5;
  reg          clock, nrst, regWrite, regRead;
  reg  [2:0]   regAddr;
  reg  [31:0]  regWdata, rnd;
  reg  [W-1:0] ext;
  wire [31:0]  regRdata;
  wire         regRvalid, irq;
  wire [W-1:0] portOut, portOe, pins;
  integer      err_total, n_checks, i, outM, dirM, maskM, flagM, prevM;
  pio_port #(.WIDTH(W), .DIR_MODE(`PIO_MODE_BIDIR), .OUT_RESET(RST_OUT)) i_dut (.clock(clock), .nrst(nrst),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .irq(irq), .portIn(pins), .portOut(portOut), .portOe(portOe));
  pio_pin_model #(.WIDTH(W)) i_pins (.portOut(portOut), .portOe(portOe), .extDrive(ext), .pinLevel(pins));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [2:0] a, input [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    #1;
  endtask
  // read data is looked at in the single cycle the valid pulse stands
  task rd(input [2:0] a, input [31:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk(regRvalid, 1);
    chk(regRdata, exp);
  endtask
  // pins pass a four-flop synchroniser, so allow eight cycles
  task settle;
    repeat (8) @(posedge clock);
    #1;
  endtask
  task give_verdict;
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    err_total = 0;
    n_checks = 0;
    rnd = 32'h51d1;
    {nrst, regWrite, regRead, regAddr, regWdata, ext} = 0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1;
    chk(portOut, RST_OUT);
    chk(portOe, 0);
    rd(`PIO_REG_IRQMASK, 0);
    rd(`PIO_REG_DIR, 0);
    for (i = 0; i < 6; i = i + 1) begin
      rnd = lfsr(rnd);
      wr(`PIO_REG_DATA, rnd);
      outM = rnd & 8'hFF;
      chk(portOut, outM);
      wr(`PIO_REG_DIR, rnd >> 8);
      dirM = (rnd >> 8) & 8'hFF;
      chk(portOe, dirM);
      wr(`PIO_REG_OUTSET, rnd >> 16);
      outM = (outM | (rnd >> 16)) & 8'hFF;
      wr(`PIO_REG_OUTCLR, rnd >> 24);
      outM = outM & ~(rnd >> 24) & 8'hFF;
      chk(portOut, outM);
      ext <= rnd[15:8] ^ rnd[31:24];
      settle;
      rd(`PIO_REG_DATA, ((outM & dirM) | (ext & ~dirM)) & 8'hFF);
    end
    wr(`PIO_REG_DIR, 0);
    settle;
    wr(`PIO_REG_EDGE, 32'hFF);
    flagM = 0;
    prevM = ext;
    for (i = 0; i < 8; i = i + 1) begin
      rnd = lfsr(rnd);
      @(posedge clock);
      ext <= rnd[7:0];
      settle;
      flagM = flagM | (ext & ~prevM);
      prevM = ext;
      rd(`PIO_REG_EDGE, flagM);
      wr(`PIO_REG_IRQMASK, rnd >> 8);
      maskM = (rnd >> 8) & 8'hFF;
      repeat (2) @(posedge clock);
      #1;
      chk(irq, (flagM & maskM) != 0);
      wr(`PIO_REG_EDGE, rnd >> 16);
      flagM = flagM & ~(rnd >> 16) & 8'hFF;
      repeat (2) @(posedge clock);
      #1;
      chk(irq, (flagM & maskM) != 0);
    end
    wr(`PIO_REG_IRQMASK, 0);
    repeat (2) @(posedge clock);
    #1;
    chk(irq, 0);
    rd(3'h6, 0);
    rd(3'h7, 0);
    give_verdict;
  end
endmodule // tb_parallel_io_port_with_irq
